// ==== verilog/set_select_pkg.sv ====
// Package: constants and carriers for the line-addressed parameter set select
package set_select_pkg;
  localparam int PARAM_W = 32;
  localparam int SET_MAX = 2;
  localparam logic [1:0] SET_COUNT_MAX = 2'h2;
  localparam logic ADDR_BIT_ZERO = 1'h0;
  localparam logic [1:0] ORIGIN_LINE_ONE = 2'h1;
  localparam int SYNC_STAGES = 3;
  localparam logic [PARAM_W-1:0] LIVE_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    POLICY_AUTO = 2'b00,
    POLICY_LINE = 2'b01
  } step_policy_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_FRAME = 2'b10,
    ST_SETTLE = 2'b11
  } sel_state_t;

  typedef struct packed {
    logic set_switching_on;
    step_policy_t set_step_policy;
    logic [1:0] stored_set_count;
    logic slot_pointer;
    logic addr_bit_pick;
    logic [1:0] addr_bit_origin;
    logic line_invert;
  } sel_cfg_t;
endpackage : set_select_pkg

// ==== verilog/set_store_mem.sv ====
// Two-slot storage for saved parameter sets with registered read data
`timescale 1ns/1ps
`default_nettype none
module set_store_mem
  import set_select_pkg::*;
#(
  parameter int WIDTH = PARAM_W,
  parameter int DEPTH = SET_MAX
)
(
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    rd_data <= mem_ff[rd_addr];
  end
endmodule : set_store_mem
`default_nettype wire

// ==== verilog/line_addressed_param_set_select.sv ====
// Line-addressed selection of stored parameter sets per frame
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Stored sets are numbered by index, first set is zero.
// - Set address is the binary index; control line drives bit 0.
// - Inversion off: high line means bit 1, low means 0.
// - Inversion on: low line means bit 1, high means 0.
// - Set count accepts at most two.
// - Address bit 0 is default pick; host assigns input line one.
// - Slot pointer accepts only 0 and 1.
// - Store copies live parameters into pointed slot, overwriting it; the code ignores store while switching is on.
// - Each trigger while waiting with line stable samples line and loads addressed set.
// - While line changes, leave waiting state and ignore triggers.
// - Switching off finishes frame and restores pre-enable live values.
module line_addressed_param_set_select
  import set_select_pkg::*;
#(
  parameter int WIDTH = PARAM_W
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire sel_cfg_t cfg,
  input wire logic save_live_to_slot,
  input wire logic live_wr_en,
  input wire logic [WIDTH-1:0] live_wr_data,
  input wire logic control_input_one,
  input wire logic frame_trigger,
  input wire logic frame_done,
  output logic [WIDTH-1:0] live_params,
  output logic waiting_for_trigger,
  output logic frame_active,
  output logic current_set,
  output logic trigger_ignored,
  output logic [1:0] set_count_held
);
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [SYNC_STAGES-1:0] line_sync_ff;
  logic line_stable;
  logic line_level;
  logic addr_bit;
  sel_state_t state_ff;
  sel_state_t nxt_state;
  logic [WIDTH-1:0] saved_live_ff;
  logic load_pending_ff;
  logic load_set_ff;
  logic [WIDTH-1:0] mem_rd;
  logic switch_on_d_ff;
  logic cfg_ok;
  logic slot_ok;
  logic take_trig;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync_ff <= 2'h0;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_sync_ff <= '0;
    end
    else
    begin
      line_sync_ff <= {line_sync_ff[SYNC_STAGES-2:0], control_input_one};
    end
  end
  // Stage 0 feeds only stage 1; stages 1 and 2 must agree
  assign line_stable = (line_sync_ff[1] == line_sync_ff[2]);
  assign line_level = line_sync_ff[2];
  assign addr_bit = cfg.line_invert ? ~line_level : line_level;

  // Set count held at most two, pointer at most one
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      set_count_held <= 2'h0;
    end
    else if (!cfg.set_switching_on)
    begin
      set_count_held <= (cfg.stored_set_count > SET_COUNT_MAX) ?
                        SET_COUNT_MAX : cfg.stored_set_count;
    end
  end
  assign slot_ok = (cfg.slot_pointer <= 1'h1);
  assign cfg_ok = (cfg.set_step_policy == POLICY_LINE) &&
                  (cfg.addr_bit_pick == ADDR_BIT_ZERO) &&
                  (cfg.addr_bit_origin == ORIGIN_LINE_ONE);

  set_store_mem #(.WIDTH(WIDTH), .DEPTH(SET_MAX)) u_mem (
    .core_clk(core_clk),
    .wr_en(save_live_to_slot && slot_ok && !cfg.set_switching_on),
    .wr_addr(cfg.slot_pointer),
    .wr_data(live_params),
    .rd_addr(load_set_ff),
    .rd_data(mem_rd)
  );

  assign take_trig = frame_trigger && (state_ff == ST_WAIT) && line_stable &&
                     cfg.set_switching_on;
  assign trigger_ignored = frame_trigger && !take_trig &&
                           (state_ff == ST_WAIT || state_ff == ST_SETTLE);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (cfg.set_switching_on && cfg_ok)
        begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (!cfg.set_switching_on)
        begin
          nxt_state = ST_IDLE;
        end
        else if (!line_stable)
        begin
          nxt_state = ST_SETTLE;
        end
        else if (take_trig)
        begin
          nxt_state = ST_FRAME;
        end
      end
      ST_SETTLE:
      begin
        if (line_stable)
        begin
          nxt_state = cfg.set_switching_on ? ST_WAIT : ST_IDLE;
        end
      end
      ST_FRAME:
      begin
        if (frame_done)
        begin
          nxt_state = cfg.set_switching_on ? ST_WAIT : ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Sample address at trigger; load memory data into live values three cycles later
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_set_ff <= 1'h0;
      load_pending_ff <= 1'h0;
    end
    else
    begin
      load_pending_ff <= take_trig;
      if (take_trig)
      begin
        load_set_ff <= addr_bit;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switch_on_d_ff <= 1'h0;
    end
    else
    begin
      switch_on_d_ff <= (state_ff != ST_IDLE);
    end
  end

  // Snapshot live values when switching starts
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      saved_live_ff <= LIVE_RESET;
    end
    else if (state_ff == ST_IDLE && nxt_state != ST_IDLE)
    begin
      saved_live_ff <= live_params;
    end
  end

  // Memory read lags address by one cycle, so wait two after trigger
  logic load_now_ff;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_now_ff <= 1'h0;
    end
    else
    begin
      load_now_ff <= load_pending_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      live_params <= LIVE_RESET;
    end
    else if (load_now_ff)
    begin
      live_params <= mem_rd;
    end
    else if (switch_on_d_ff && state_ff == ST_IDLE)
    begin
      live_params <= saved_live_ff;
    end
    else if (live_wr_en && state_ff == ST_IDLE)
    begin
      live_params <= live_wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      current_set <= 1'h0;
    end
    else if (take_trig)
    begin
      current_set <= addr_bit;
    end
  end

  assign waiting_for_trigger = (state_ff == ST_WAIT) && line_stable;
  assign frame_active = (state_ff == ST_FRAME);

  AST_LOAD_AFTER_TRIG:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      take_trig |-> ##1 (current_set == $past(addr_bit)) ##2
      (live_params == $past(mem_rd)))
    else $error("Addressed set not loaded after trigger");
  AST_IGNORE_UNSTABLE:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (!line_stable && frame_trigger) |=> (state_ff != ST_FRAME))
    else $error("Trigger accepted while line changing");
  AST_COUNT_MAX:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      set_count_held <= SET_COUNT_MAX)
    else $error("Set count above two");
  AST_NONINV:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (take_trig && !cfg.line_invert) |=> (current_set == $past(line_level)))
    else $error("Non-inverted address wrong");
  AST_INV:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (take_trig && cfg.line_invert) |=> (current_set != $past(line_level)))
    else $error("Inverted address wrong");
  AST_RESTORE:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (switch_on_d_ff && state_ff == ST_IDLE && !load_now_ff) |=>
      (live_params == $past(saved_live_ff)))
    else $error("Live values not restored");
  AST_FRAME_HOLD:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (frame_active && !frame_done) |=> frame_active)
    else $error("Frame cut short");
  AST_WAIT_ONLY_STABLE:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_ff == ST_WAIT && !line_stable && cfg.set_switching_on) |=>
      (state_ff == ST_SETTLE && !waiting_for_trigger))
    else $error("Waiting while line moving");
endmodule : line_addressed_param_set_select
`default_nettype wire

// ==== tb/far_side_model.sv ====
// Far side model: control line, frame trigger source and frame end
`timescale 1ns/1ps
`default_nettype none
module far_side_model
(
  input wire logic core_clk,
  input wire logic line_level,
  input wire logic fire,
  input wire logic storm,
  input wire logic waiting_for_trigger,
  input wire logic frame_active,
  output logic control_input_one,
  output logic frame_trigger,
  output logic frame_done
);
  logic pend_ff;
  logic [3:0] quiet_ff;
  logic [3:0] fcnt_ff;
  logic [2:0] scnt_ff;
  initial
  begin
    {control_input_one, frame_trigger, frame_done, pend_ff} = 4'h0;
    {quiet_ff, fcnt_ff, scnt_ff} = 11'h0;
  end
  // Storm toggles the line every cycle and triggers into it on purpose
  always @(posedge core_clk)
  begin
    control_input_one <= storm ? ~control_input_one : line_level;
    scnt_ff <= !storm ? 3'h0 : (scnt_ff == 3'h7) ? scnt_ff : scnt_ff + 3'h1;
    if (storm || control_input_one != line_level)
      quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hF)
      quiet_ff <= quiet_ff + 4'h1;
  end
  // Outside a storm, trigger only once the line is quiet and the device waits
  always @(posedge core_clk)
  begin
    if (storm)
      frame_trigger <= (scnt_ff >= 3'h4);
    else
      frame_trigger <= pend_ff && waiting_for_trigger && quiet_ff >= 4'h8 &&
        !frame_trigger;
    if (fire)
      pend_ff <= 1'b1;
    else if (frame_trigger && !storm)
      pend_ff <= 1'b0;
  end
  always @(posedge core_clk)
  begin
    fcnt_ff <= frame_active ? fcnt_ff + 4'h1 : 4'h0;
    frame_done <= frame_active && fcnt_ff == 4'h4;
  end
endmodule : far_side_model
`default_nettype wire

// ==== tb/test_line_addressed_param_set_select.sv ====
// Testbench for the line-addressed parameter set select
`timescale 1ns/1ps
`default_nettype none
module test_line_addressed_param_set_select
  import set_select_pkg::*;
;
  logic core_clk, reset_n, save, lwe, line, fire, storm, seen_clr;
  logic ctl, trig, done, wft, fact, cset, ign, seen_ign, seen_fr;
  logic [31:0] lwd, live;
  logic [1:0] cnt;
  sel_cfg_t cfg;
  int err_count, checks;
  line_addressed_param_set_select u_line_addressed_param_set_select (
    .core_clk(core_clk), .reset_n(reset_n), .cfg(cfg),
    .save_live_to_slot(save), .live_wr_en(lwe), .live_wr_data(lwd),
    .control_input_one(ctl), .frame_trigger(trig), .frame_done(done),
    .live_params(live), .waiting_for_trigger(wft), .frame_active(fact),
    .current_set(cset), .trigger_ignored(ign), .set_count_held(cnt));
  far_side_model u_far_side_model (.core_clk(core_clk), .line_level(line),
    .fire(fire), .storm(storm), .waiting_for_trigger(wft),
    .frame_active(fact), .control_input_one(ctl), .frame_trigger(trig),
    .frame_done(done));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (seen_clr)
    begin
      seen_ign <= 1'b0;
      seen_fr <= 1'b0;
    end
    else
    begin
      if (ign === 1'b1) seen_ign <= 1'b1;
      if (fact === 1'b1) seen_fr <= 1'b1;
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic ck(int n);
    repeat (n) @(posedge core_clk);
  endtask : ck
  task automatic live_write(logic [31:0] v);
    @(posedge core_clk);
    lwd <= v;
    lwe <= 1'b1;
    @(posedge core_clk);
    lwe <= 1'b0;
  endtask : live_write
  task automatic store(logic slot);
    @(posedge core_clk);
    cfg.slot_pointer <= slot;
    @(posedge core_clk);
    save <= 1'b1;
    @(posedge core_clk);
    save <= 1'b0;
  endtask : store
  task automatic frame(logic lvl, logic s, logic [31:0] v);
    int i;
    @(posedge core_clk);
    line <= lvl;
    ck(14);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge core_clk);
    chk("frame_done", done, 1'b1);
    @(negedge core_clk);
    chk("current_set", cset, s);
    chk("live_params", live, v);
  endtask : frame
  task automatic t_reset();
    reset_n <= 1'b0;
    ck(8);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk("reset live", live, 32'h0);
    chk("reset set", {fact, cset, cnt}, 4'h0);
    ck(4);
    $display("test reset done");
  endtask : t_reset
  task automatic t_populate();
    cfg.stored_set_count <= 2'h3;
    live_write(32'hA5A5_0001);
    store(1'b0);
    live_write(32'h5A5A_0002);
    store(1'b1);
    live_write(32'h0000_0C0C);
    ck(2);
    chk("set_count_held", cnt, SET_COUNT_MAX);
    chk("live after write", live, 32'h0000_0C0C);
    cfg.stored_set_count <= 2'h2;
    $display("test populate done");
  endtask : t_populate
  task automatic t_select(logic inv);
    @(posedge core_clk);
    cfg.line_invert <= inv;
    @(posedge core_clk);
    cfg.set_switching_on <= 1'b1;
    frame(inv, 1'b0, 32'hA5A5_0001);
    store(1'b1);
    frame(~inv, 1'b1, 32'h5A5A_0002);
    frame(inv, 1'b0, 32'hA5A5_0001);
    $display("test select done");
  endtask : t_select
  task automatic t_storm();
    ck(12);
    seen_clr <= 1'b0;
    storm <= 1'b1;
    ck(8);
    storm <= 1'b0;
    ck(6);
    chk("trigger_ignored", seen_ign, 1'b1);
    chk("frame during change", seen_fr, 1'b0);
    $display("test storm done");
  endtask : t_storm
  task automatic t_cut();
    int i;
    @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    for (i = 0; i < 50 && fact !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    cfg.set_switching_on <= 1'b0;
    ck(2);
    @(negedge core_clk);
    chk("frame kept", fact, 1'b1);
    for (i = 0; i < 50 && fact === 1'b1; i++) @(negedge core_clk);
    ck(4);
    @(negedge core_clk);
    chk("cut restore", live, 32'h0000_0C0C);
    @(posedge core_clk);
    cfg.set_step_policy <= POLICY_AUTO;
    cfg.set_switching_on <= 1'b1;
    ck(4);
    @(negedge core_clk);
    chk("auto policy idle", wft, 1'b0);
    @(posedge core_clk);
    cfg.set_step_policy <= POLICY_LINE;
    cfg.set_switching_on <= 1'b0;
    $display("test cut done");
  endtask : t_cut
  task automatic t_restore();
    @(posedge core_clk);
    cfg.set_switching_on <= 1'b0;
    ck(10);
    @(negedge core_clk);
    chk("restored live", live, 32'h0000_0C0C);
    chk("waiting off", wft, 1'b0);
    $display("test restore done");
  endtask : t_restore
  initial
  begin
    {reset_n, save, lwe, line, fire, storm} = 6'h0;
    seen_clr = 1'b1;
    lwd = 32'h0;
    cfg = '{1'b0, POLICY_LINE, 2'h2, 1'b0, ADDR_BIT_ZERO, ORIGIN_LINE_ONE,
      1'b0};
    t_reset();
    t_populate();
    t_select(1'b0);
    t_storm();
    t_restore();
    t_select(1'b1);
    t_cut();
    t_restore();
    report_and_stop();
  end
  initial
  begin
    ck(20000);
    err_count++;
    report_and_stop();
  end
endmodule : test_line_addressed_param_set_select
`default_nettype wire
